// *** design/port_pin_pkg.sv ***
// Shared constants for the port pin block: pin layout, register word
// indices, reset values and bus handshake states.
// Assumes an Avalon-MM master that addresses 32-bit words by index.
package port_pin_pkg;

  // ****************************************************************
  // Pin layout in the flat pin vector
  // ****************************************************************
  localparam int NUM_PINS = 16;
  localparam int PA_W = 6;
  localparam int PC_W = 2;
  localparam int PD_W = 8;
  localparam int PA_LSB = 0;
  localparam int PC_LSB = 6;
  localparam int PD_LSB = 8;
  localparam int DRV_W = PA_W + PC_W;
  localparam int SPI_W = 4;
  localparam int DL_NARROW_W = 4;
  localparam int PC_IRQ_BIT = 1;
  localparam int PC_CLK_BIT = 0;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;

  // ****************************************************************
  // Register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_PTA = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_PTC = 9'h002;
  localparam logic [ADDR_W-1:0] OFS_PTD = 9'h003;
  localparam logic [ADDR_W-1:0] OFS_DDRA = 9'h004;
  localparam logic [ADDR_W-1:0] OFS_DDRC = 9'h006;
  localparam logic [ADDR_W-1:0] OFS_DDRD = 9'h007;
  localparam logic [ADDR_W-1:0] OFS_PTIA = 9'h120;
  localparam logic [ADDR_W-1:0] OFS_RDRA = 9'h122;
  localparam logic [ADDR_W-1:0] OFS_RSVD_LO = 9'h123;
  localparam logic [ADDR_W-1:0] OFS_RSVD_HI = 9'h17f;
  localparam logic [ADDR_W-1:0] OFS_PTIC = 9'h180;
  localparam logic [ADDR_W-1:0] OFS_PTID = 9'h181;
  localparam logic [ADDR_W-1:0] OFS_RDRC = 9'h182;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [NUM_PINS-1:0] RST_PINS = 16'h0000;
  localparam logic [DRV_W-1:0] RST_DRV = 8'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // Bus handshake states
  // ****************************************************************
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

endpackage

// *** design/pin_sync_if.sv ***
// Carrier between the port block and its input synchroniser.
// Assumes both ends share the bus clock.
interface pin_sync_if import port_pin_pkg::*; ();
  logic [NUM_PINS-1:0] raw;
  logic [NUM_PINS-1:0] sync;

  // The port block feeds raw pins and reads the settled levels
  modport src (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface

// *** design/pin_input_sync.sv ***
// Two-stage synchroniser for every pin input of the port block.
// Assumes raw pins may change at any time relative to the bus clock.
module pin_input_sync import port_pin_pkg::*; (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Pin levels in and settled levels out
  pin_sync_if.syncer sif
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_PINS-1:0] stage1;
    logic [NUM_PINS-1:0] stage2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Only the second stage reads the first one, to let metastability settle
  always_comb begin
    next_st = st;
    next_st.stage1 = sif.raw;
    next_st.stage2 = st.stage1;
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st <= '{stage1: RST_PINS, stage2: RST_PINS};
    end else begin
      st <= next_st;
    end
  end

  // Settled levels to the port block
  assign sif.sync = st.stage2;

endmodule

// *** design/port_pin_io_control.sv ***
// Port pin logic for ports A (6 pins), C (2 pins) and internal port D
// (8 pins): output latches, direction bits, input samples, drive select
// and takeover by the SPI and the die-link interface.
// Assumes an Avalon-MM master, a stop-mode flag from the clock unit and
// pad cells that honour the enables, drive and pull-down outputs.
//
// Decided for this implementation: register access over Avalon-MM.
module port_pin_io_control import port_pin_pkg::*; (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [BE_W-1:0] i_avs_byteenable,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Port A pins
  input wire logic [PA_W-1:0] i_pa_in,
  output logic [PA_W-1:0] o_pa_out,
  output logic [PA_W-1:0] o_pa_oe,
  output logic [PA_W-1:0] o_pa_reduced,
  // Port C pins
  input wire logic [PC_W-1:0] i_pc_in,
  output logic [PC_W-1:0] o_pc_out,
  output logic [PC_W-1:0] o_pc_oe,
  output logic [PC_W-1:0] o_pc_reduced,
  output logic [PC_W-1:0] o_pc_pulldown,
  // Port D internal lines
  input wire logic [PD_W-1:0] i_pd_in,
  output logic [PD_W-1:0] o_pd_out,
  output logic [PD_W-1:0] o_pd_oe,
  output logic [PD_W-1:0] o_pd_pulldown,
  // SPI module
  input wire logic i_spi_enable,
  input wire logic [SPI_W-1:0] i_spi_out,
  input wire logic [SPI_W-1:0] i_spi_oe,
  output logic [SPI_W-1:0] o_spi_in,
  // Die-link interface
  input wire logic i_dl_enable,
  input wire logic i_dl_narrow,
  input wire logic i_dl_clk_out,
  input wire logic [PD_W-1:0] i_dl_data_out,
  input wire logic i_dl_data_oe,
  output logic [PD_W-1:0] o_dl_data_in,
  output logic o_dl_irq,
  output logic o_dl_wake,
  // Power mode
  input wire logic i_stop_mode
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bus_state_t bus;
    logic [NUM_PINS-1:0] latch;
    logic [NUM_PINS-1:0] ddr;
    logic [DRV_W-1:0] rdr;
    logic [DATA_W-1:0] rdata;
  } regs_t;

  regs_t st;
  regs_t next_st;

  pin_sync_if sif ();

  logic [NUM_PINS-1:0] own;
  logic [NUM_PINS-1:0] per_out;
  logic [NUM_PINS-1:0] per_oe;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] sample;
  logic req;
  logic wr_lane;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // The reserved hole is decoded in both the read and the write path
  function automatic logic is_reserved(input logic [ADDR_W-1:0] addr);
    is_reserved = (addr >= OFS_RSVD_LO) && (addr <= OFS_RSVD_HI);
  endfunction

  // Latch read-back picks per pin on the direction bit and nothing else
  function automatic logic [NUM_PINS-1:0] latch_view(input logic [NUM_PINS-1:0] ddr,
                                                     input logic [NUM_PINS-1:0] latch,
                                                     input logic [NUM_PINS-1:0] smp);
    latch_view = (ddr & latch) | (~ddr & smp);
  endfunction

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************

  // Raw pins enter in flat order A, C, D from bit 0 upward
  assign sif.raw = {i_pd_in, i_pc_in, i_pa_in};
  assign sample = sif.sync;

  pin_input_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .sif(sif)
  );

  // ****************************************************************
  // Peripheral ownership
  // ****************************************************************

  // Ownership comes straight from the peripherals, so the stored direction
  // bits are never written here and survive a takeover untouched
  always_comb begin
    own = '0;
    per_out = '0;
    per_oe = '0;
    // SPI takes the low four port A pins; the top two stay GPIO only
    own[PA_LSB +: SPI_W] = {SPI_W{i_spi_enable}};
    per_out[PA_LSB +: SPI_W] = i_spi_out;
    per_oe[PA_LSB +: SPI_W] = i_spi_oe;
    // Port C: pin 1 receives the link interrupt, pin 0 drives the link clock
    own[PC_LSB + PC_IRQ_BIT] = i_dl_enable;
    per_oe[PC_LSB + PC_IRQ_BIT] = 1'b0;
    own[PC_LSB + PC_CLK_BIT] = i_dl_enable;
    per_out[PC_LSB + PC_CLK_BIT] = i_dl_clk_out;
    per_oe[PC_LSB + PC_CLK_BIT] = 1'b1;
    // Port D: lower half always with the link, upper half only when wide
    own[PD_LSB +: DL_NARROW_W] = {DL_NARROW_W{i_dl_enable}};
    own[PD_LSB + DL_NARROW_W +: DL_NARROW_W] = {DL_NARROW_W{i_dl_enable & ~i_dl_narrow}};
    per_out[PD_LSB +: PD_W] = i_dl_data_out;
    per_oe[PD_LSB +: PD_W] = {PD_W{i_dl_data_oe}};
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************

  // Each pin chooses between its GPIO controls and its owner
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      assign pin_oe[p] = own[p] ? per_oe[p] : st.ddr[p];
      assign pin_out[p] = own[p] ? per_out[p] : st.latch[p];
    end
  endgenerate

  // The latch reaches a pad only through the enable, so a write to an input
  // pin changes nothing outside
  assign o_pa_out = pin_out[PA_LSB +: PA_W];
  assign o_pa_oe = pin_oe[PA_LSB +: PA_W];
  assign o_pc_out = pin_out[PC_LSB +: PC_W];
  assign o_pc_oe = pin_oe[PC_LSB +: PC_W];
  assign o_pd_out = pin_out[PD_LSB +: PD_W];
  assign o_pd_oe = pin_oe[PD_LSB +: PD_W];

  // Reduced drive asks for one sixth strength, gated by the output enable
  assign o_pa_reduced = st.rdr[PA_LSB +: PA_W] & pin_oe[PA_LSB +: PA_W];
  assign o_pc_reduced = st.rdr[PA_W +: PC_W] & pin_oe[PC_LSB +: PC_W];

  // ****************************************************************
  // Pull-downs and peripheral inputs
  // ****************************************************************

  // Keep link inputs from floating while the far die is quiet
  assign o_pc_pulldown = {own[PC_LSB + PC_IRQ_BIT], 1'b0};
  assign o_pd_pulldown = own[PD_LSB +: PD_W] & ~per_oe[PD_LSB +: PD_W];

  // Peripherals see the same settled levels as software
  assign o_spi_in = sample[PA_LSB +: SPI_W];
  assign o_dl_data_in = sample[PD_LSB +: PD_W];
  assign o_dl_irq = sample[PC_LSB + PC_IRQ_BIT] & own[PC_LSB + PC_IRQ_BIT];

  // The wake path reads the raw pad, since no clock runs in stop mode;
  // it is a combinational output and may glitch with the pin
  assign o_dl_wake = i_stop_mode & i_dl_enable & i_pc_in[PC_IRQ_BIT];

  // ****************************************************************
  // Register bus
  // ****************************************************************

  // Every access takes one wait cycle, then completes
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & (st.bus == BUS_IDLE);
  assign o_avs_readdata = st.rdata;
  assign wr_lane = i_avs_write & i_avs_byteenable[0];

  // Next-state logic: read data is captured in the wait cycle, writes land
  // on the completing edge only
  always_comb begin
    next_st = st;
    case (st.bus)
      BUS_IDLE: begin
        if (req) begin
          next_st.bus = BUS_ACK;
        end
        if (i_avs_read) begin
          if (is_reserved(i_avs_address)) begin
            next_st.rdata = RST_WORD;
          end else begin
            case (i_avs_address)
              OFS_PTA: begin
                next_st.rdata = DATA_W'(latch_view(st.ddr, st.latch, sample) >> PA_LSB) & DATA_W'({PA_W{1'b1}});
              end
              OFS_PTC: begin
                next_st.rdata = DATA_W'(latch_view(st.ddr, st.latch, sample) >> PC_LSB) & DATA_W'({PC_W{1'b1}});
              end
              OFS_PTD: begin
                next_st.rdata = DATA_W'(latch_view(st.ddr, st.latch, sample) >> PD_LSB) & DATA_W'({PD_W{1'b1}});
              end
              OFS_DDRA: begin
                next_st.rdata = DATA_W'(st.ddr[PA_LSB +: PA_W]);
              end
              OFS_DDRC: begin
                next_st.rdata = DATA_W'(st.ddr[PC_LSB +: PC_W]);
              end
              OFS_DDRD: begin
                next_st.rdata = DATA_W'(st.ddr[PD_LSB +: PD_W]);
              end
              OFS_PTIA: begin
                next_st.rdata = DATA_W'(sample[PA_LSB +: PA_W]);
              end
              OFS_PTIC: begin
                next_st.rdata = DATA_W'(sample[PC_LSB +: PC_W]);
              end
              OFS_PTID: begin
                next_st.rdata = DATA_W'(sample[PD_LSB +: PD_W]);
              end
              OFS_RDRA: begin
                next_st.rdata = DATA_W'(st.rdr[PA_LSB +: PA_W]);
              end
              OFS_RDRC: begin
                next_st.rdata = DATA_W'(st.rdr[PA_W +: PC_W]);
              end
              default: begin
                next_st.rdata = RST_WORD;
              end
            endcase
          end
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        // Reserved words and the input samples have no write path at all
        if (wr_lane && !is_reserved(i_avs_address)) begin
          case (i_avs_address)
            OFS_PTA: begin
              next_st.latch[PA_LSB +: PA_W] = i_avs_writedata[PA_W-1:0];
            end
            OFS_PTC: begin
              next_st.latch[PC_LSB +: PC_W] = i_avs_writedata[PC_W-1:0];
            end
            OFS_PTD: begin
              next_st.latch[PD_LSB +: PD_W] = i_avs_writedata[PD_W-1:0];
            end
            OFS_DDRA: begin
              next_st.ddr[PA_LSB +: PA_W] = i_avs_writedata[PA_W-1:0];
            end
            OFS_DDRC: begin
              next_st.ddr[PC_LSB +: PC_W] = i_avs_writedata[PC_W-1:0];
            end
            OFS_DDRD: begin
              next_st.ddr[PD_LSB +: PD_W] = i_avs_writedata[PD_W-1:0];
            end
            OFS_RDRA: begin
              next_st.rdr[PA_LSB +: PA_W] = i_avs_writedata[PA_W-1:0];
            end
            OFS_RDRC: begin
              next_st.rdr[PA_W +: PC_W] = i_avs_writedata[PC_W-1:0];
            end
            default: begin
              next_st.bus = BUS_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_st.bus = BUS_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // All pins come up as inputs with full drive and cleared latches
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st <= '{bus: BUS_IDLE, latch: RST_PINS, ddr: RST_PINS, rdr: RST_DRV, rdata: RST_WORD};
    end else begin
      st <= next_st;
    end
  end

endmodule

// *** dv/port_pin_io_control_checker.sv ***
// Checker for the port pin block, bound to its top-level ports.
// Assumes one bus clock and a synchronous active-low reset.
module port_pin_checker import port_pin_pkg::*; (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic [DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Pins
  input wire logic [PA_W-1:0] o_pa_out,
  input wire logic [PA_W-1:0] o_pa_oe,
  input wire logic [PA_W-1:0] o_pa_reduced,
  input wire logic [PC_W-1:0] i_pc_in,
  input wire logic [PC_W-1:0] o_pc_out,
  input wire logic [PC_W-1:0] o_pc_oe,
  input wire logic [PC_W-1:0] o_pc_reduced,
  input wire logic [PC_W-1:0] o_pc_pulldown,
  input wire logic [PD_W-1:0] o_pd_out,
  input wire logic [PD_W-1:0] o_pd_oe,
  input wire logic [PD_W-1:0] o_pd_pulldown,
  // Peripherals and power
  input wire logic i_spi_enable,
  input wire logic [SPI_W-1:0] i_spi_out,
  input wire logic [SPI_W-1:0] i_spi_oe,
  input wire logic i_dl_enable,
  input wire logic i_dl_narrow,
  input wire logic i_dl_clk_out,
  input wire logic [PD_W-1:0] i_dl_data_out,
  input wire logic i_dl_data_oe,
  input wire logic o_dl_irq,
  input wire logic o_dl_wake,
  input wire logic i_stop_mode
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Reserved words answer zero at the completion cycle
  a_rsvd_reads_zero: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address >= OFS_RSVD_LO && i_avs_address <= OFS_RSVD_HI
    |-> o_avs_readdata == RST_WORD) else $error("reserved read not zero");
  a_spi_takes_pins: assert property (i_spi_enable |->
    o_pa_out[3:0] == i_spi_out && o_pa_oe[3:0] == i_spi_oe) else $error("spi pins not owned");
  a_reduced_needs_oe: assert property (
    (o_pa_reduced & ~o_pa_oe) == '0 && (o_pc_reduced & ~o_pc_oe) == '0) else $error("reduced drive on input");
  a_irq_pulldown: assert property (
    o_pc_pulldown == {i_dl_enable, 1'b0}) else $error("irq pin pull-down wrong");
  a_link_pulldown: assert property (
    o_pd_pulldown == ({8{i_dl_enable & ~i_dl_data_oe}} & (i_dl_narrow ? 8'h0f : 8'hff)))
    else $error("link data pull-down wrong");
  a_link_clk_pin: assert property (i_dl_enable |->
    o_pc_oe == 2'b01 && o_pc_out[0] == i_dl_clk_out) else $error("link clock pin wrong");
  a_link_data_pins: assert property (i_dl_enable |->
    o_pd_oe[3:0] == {4{i_dl_data_oe}} && o_pd_out[3:0] == i_dl_data_out[3:0]) else $error("link data pins wrong");
  a_wake_bypass: assert property (
    o_dl_wake == (i_stop_mode & i_dl_enable & i_pc_in[1])) else $error("wake bypass wrong");
  // Two clean edges are needed before the synchroniser shows the pin
  a_irq_two_stage: assert property ($past(i_rst_n) && $past(i_rst_n, 2) |->
    o_dl_irq == (i_dl_enable & $past(i_pc_in[1], 2))) else $error("irq not two-stage synced");

  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************
  c_spi: cover property (i_spi_enable && i_spi_oe != '0);
  c_narrow: cover property (i_dl_enable && i_dl_narrow && i_dl_data_oe);
  c_wake: cover property (o_dl_wake);
  c_rsvd: cover property (i_avs_read && !o_avs_waitrequest && i_avs_address == OFS_RSVD_HI);
endmodule

bind port_pin_io_control port_pin_checker chk_u (.i_sys_clk, .i_rst_n, .i_avs_address, .i_avs_read,
  .o_avs_readdata, .o_avs_waitrequest, .o_pa_out, .o_pa_oe, .o_pa_reduced, .i_pc_in, .o_pc_out, .o_pc_oe,
  .o_pc_reduced, .o_pc_pulldown, .o_pd_out, .o_pd_oe, .o_pd_pulldown, .i_spi_enable, .i_spi_out, .i_spi_oe,
  .i_dl_enable, .i_dl_narrow, .i_dl_clk_out, .i_dl_data_out, .i_dl_data_oe, .o_dl_irq, .o_dl_wake, .i_stop_mode);

// *** dv/pin_partner.sv ***
// Pad model: resolves pin levels from the block's enables and the outside.
// Assumes the bench drives the outside levels of ports A and C.
module pin_partner import port_pin_pkg::*; (
  // Clock
  input wire logic i_sys_clk,
  // Block side
  input wire logic [PA_W-1:0] i_pa_out,
  input wire logic [PA_W-1:0] i_pa_oe,
  input wire logic [PC_W-1:0] i_pc_out,
  input wire logic [PC_W-1:0] i_pc_oe,
  input wire logic [PD_W-1:0] i_pd_out,
  input wire logic [PD_W-1:0] i_pd_oe,
  input wire logic [PD_W-1:0] i_pd_pulldown,
  // Outside drivers
  input wire logic [PA_W-1:0] i_pa_ext,
  input wire logic [PC_W-1:0] i_pc_ext,
  // Resolved levels
  output logic [PA_W-1:0] o_pa_pad,
  output logic [PC_W-1:0] o_pc_pad,
  output logic [PD_W-1:0] o_pd_pad
);
  logic [PD_W-1:0] last = '0;

  // An enabled output wins over the outside driver
  assign o_pa_pad = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_pa_ext);
  assign o_pc_pad = (i_pc_oe & i_pc_out) | (~i_pc_oe & i_pc_ext);
  // Internal lines have no outside driver: floating ones toggle, so a stale value never reads as valid
  assign o_pd_pad = (i_pd_oe & i_pd_out) | (~i_pd_oe & ~i_pd_pulldown & ~last);
  always_ff @(posedge i_sys_clk) begin
    last <= o_pd_pad;
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the port pin block.
// Assumes the pad model and the bound checker; one 250 MHz clock.
module tb import port_pin_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

  int mismatches = 0;
  int n_tests = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0, wr = 1'b0, wreq;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [PA_W-1:0] pa_ext = '0, pa_pad, pa_out, pa_oe, pa_red;
  logic [PC_W-1:0] pc_ext = '0, pc_pad, pc_out, pc_oe, pc_red, pc_pd;
  logic [PD_W-1:0] pd_pad, pd_out, pd_oe, pd_pd, dl_in, dl_dout = '0;
  logic [SPI_W-1:0] spi_out = '0, spi_oe = '0, spi_in;
  logic spi_en = 0, dl_en = 0, dl_nar = 0, dl_clk = 0, dl_doe = 0, stop = 0, irq, wake;

  // 4 ns bus clock
  always #2 clk = ~clk;

  port_pin_io_control dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_byteenable(4'h1), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_pa_in(pa_pad), .o_pa_out(pa_out), .o_pa_oe(pa_oe), .o_pa_reduced(pa_red),
    .i_pc_in(pc_pad), .o_pc_out(pc_out), .o_pc_oe(pc_oe), .o_pc_reduced(pc_red), .o_pc_pulldown(pc_pd),
    .i_pd_in(pd_pad), .o_pd_out(pd_out), .o_pd_oe(pd_oe), .o_pd_pulldown(pd_pd), .i_spi_enable(spi_en),
    .i_spi_out(spi_out), .i_spi_oe(spi_oe), .o_spi_in(spi_in), .i_dl_enable(dl_en), .i_dl_narrow(dl_nar),
    .i_dl_clk_out(dl_clk), .i_dl_data_out(dl_dout), .i_dl_data_oe(dl_doe), .o_dl_data_in(dl_in),
    .o_dl_irq(irq), .o_dl_wake(wake), .i_stop_mode(stop));
  pin_partner pads_u (.i_sys_clk(clk), .i_pa_out(pa_out), .i_pa_oe(pa_oe), .i_pc_out(pc_out), .i_pc_oe(pc_oe),
    .i_pd_out(pd_out), .i_pd_oe(pd_oe), .i_pd_pulldown(pd_pd), .i_pa_ext(pa_ext), .i_pc_ext(pc_ext),
    .o_pa_pad(pa_pad), .o_pc_pad(pc_pad), .o_pd_pad(pd_pad));

  // ****************************************************************
  // Bus and helper tasks
  // ****************************************************************
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    if (n >= 20) mismatches++;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr8(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [DATA_W-1:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
    logic [DATA_W-1:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_gpio();
    rd_chk(OFS_DDRA, 8'h00, "ddra_rst");
    pa_ext <= 6'h15;
    wr8(OFS_PTA, 8'h2a); // Latch loaded before outputs
    `CHK("pa_oe_in", 6'h00, pa_oe)
    wr8(OFS_DDRA, 8'h0f); // Separate byte access
    `CHK("pa_oe", 6'h0f, pa_oe)
    `CHK("pa_out", 4'ha, pa_out[3:0])
    rd_chk(OFS_PTA, 8'h1a, "pta_mix");
    wr8(OFS_PTIA, 8'hff);
    rd_chk(OFS_PTIA, 8'h1a, "ptia_ro");
    $display("test gpio done");
  endtask
  // SPI owns the low pins while the direction bits stay set
  task automatic t_spi();
    spi_en <= 1'b1;
    spi_oe <= 4'hf;
    spi_out <= 4'h5;
    step(3);
    `CHK("spi_pa_out", 4'h5, pa_out[3:0])
    rd_chk(OFS_PTA, 8'h1a, "pta_spi");
    rd_chk(OFS_PTIA, 8'h15, "ptia_spi");
    `CHK("spi_in", 4'h5, spi_in)
    spi_oe <= 4'h0;
    wr8(OFS_DDRA, 8'h3f);
    `CHK("pa_oe_spi", 6'h30, pa_oe)
    `CHK("pa_hi", 2'b10, pa_out[5:4])
    spi_en <= 1'b0;
    step(1);
    `CHK("pa_gpio", 6'h3f, pa_oe)
    $display("test spi done");
  endtask
  task automatic t_drive();
    wr8(OFS_RDRA, 8'h3c);
    wr8(OFS_DDRA, 8'h0f);
    `CHK("pa_red", 6'h0c, pa_red)
    rd_chk(OFS_RDRA, 8'h3c, "rdra");
    wr8(OFS_DDRC, 8'h03);
    wr8(OFS_RDRC, 8'h02);
    `CHK("pc_red", 2'b10, pc_red)
    rd_chk(OFS_RDRC, 8'h02, "rdrc");
    rd_chk(OFS_DDRC, 8'h03, "ddrc");
    $display("test drive done");
  endtask
  // Reserved bounds, a middle word and one unmapped word
  task automatic t_rsvd();
    logic [ADDR_W-1:0] adr [4] = '{9'h123, 9'h150, 9'h17f, 9'h1f0};
    foreach (adr[i]) begin
      wr8(adr[i], 8'hff);
      rd_chk(adr[i], 8'h00, "rsvd");
    end
    rd_chk(OFS_RDRA, 8'h3c, "no_side");
    $display("test reserved done");
  endtask
  task automatic t_link();
    wr8(OFS_PTD, 8'ha5);
    wr8(OFS_DDRD, 8'hff);
    pc_ext <= 2'b10;
    dl_clk <= 1'b1;
    dl_en <= 1'b1;
    step(1);
    `CHK("pc_oe", 2'b01, pc_oe)
    `CHK("pc_pd", 2'b10, pc_pd)
    `CHK("pd_pd", 8'hff, pd_pd)
    rd_chk(OFS_DDRD, 8'hff, "ddrd_kept");
    // Link owns port C, yet the set direction bits still pick the latch
    rd_chk(OFS_PTC, 8'h00, "ptc_owned");
    rd_chk(OFS_PTIC, 8'h03, "ptic");
    `CHK("irq", 1'b1, irq)
    `CHK("dl_in", 8'h00, dl_in)
    stop <= 1'b1;
    step(1);
    `CHK("wake", 1'b1, wake)
    stop <= 1'b0;
    dl_nar <= 1'b1;
    dl_doe <= 1'b1;
    dl_dout <= 8'h3c;
    step(3);
    `CHK("pd_oe_nar", 8'hff, pd_oe)
    `CHK("pd_out_nar", 8'hac, pd_out)
    `CHK("dl_in_nar", 8'hac, dl_in)
    rd_chk(OFS_PTD, 8'ha5, "ptd_latch");
    rd_chk(OFS_PTID, 8'hac, "ptid");
    $display("test link done");
  endtask

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_gpio();
    t_spi();
    t_drive();
    t_rsvd();
    t_link();
    finish_test();
  end
  // Whole run needs under two hundred cycles; this bound only catches a hang
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule
